// ---- spm_pkg.sv ----
// Constants for the serial control pin multiplexer: register map, fields, reset values, timing.
// Assumes a 50 MHz system clock and a 32-bit APB master.
// Notes on behaviour
// - After reset all three control pins are general-purpose port pins.
// - As port pins, each pin's direction follows its direction register bit.
// - A set function-select bit hands the pin to the serial port.
// - Asynchronous mode: pin zero is receiver clock, in or out, with hysteresis.
// - Synchronous mode: pin zero is transmitter 1 output or serial flag 0.
// - Asynchronous mode: pin one is receiver frame sync, driven or accepted.
// - Synchronous mode: pin one is transmitter 2 output or serial flag 1.
// - Pin two is shared frame sync in synchronous, transmit sync in asynchronous.
// - Pin two as output drives the internally generated frame sync.
// - Pin two as input feeds transmitter, and receiver in synchronous mode.
// - Transmit and receive paths work at the same time, full duplex.
// - External bit clock needs three processor phases per half period.
package spm_pkg;
	localparam int unsigned       NPIN            = 3;
	localparam int unsigned       ADDR_W          = 8;
	// ==========================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_FUNC_SEL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DIR         = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_GPIO_OUT    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PIN_LEVEL   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_SER_CFG     = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h14;
	// ==========================================
	// Serial configuration fields
	localparam int unsigned       CFG_SYNC        = 0;
	localparam int unsigned       CFG_P0_OUT      = 1;
	localparam int unsigned       CFG_P1_OUT      = 2;
	localparam int unsigned       CFG_P2_OUT      = 3;
	localparam int unsigned       CFG_P0_FLAG     = 4;
	localparam int unsigned       CFG_P1_FLAG     = 5;
	localparam int unsigned       CFG_FLAG0_OUT   = 6;
	localparam int unsigned       CFG_FLAG1_OUT   = 7;
	localparam int unsigned       CFG_CLK_CHK     = 8;
	localparam int unsigned       CFG_W           = 9;
	localparam int unsigned       STAT_CLK_FAST   = 0;
	// ==========================================
	// Reset values
	localparam logic [NPIN-1:0]   RST_FUNC_SEL    = 3'h0;
	localparam logic [NPIN-1:0]   RST_DIR         = 3'h0;
	localparam logic [NPIN-1:0]   RST_GPIO_OUT    = 3'h0;
	localparam logic [CFG_W-1:0]  RST_SER_CFG     = 9'h000;
	// ==========================================
	// Bit clock timing
	localparam int unsigned       SYS_CLK_NS      = 20;
	localparam int unsigned       SCLK_MIN_PHASES = 3;
	localparam int unsigned       SYS_PHASE_NS    = SYS_CLK_NS / 2;
	localparam int unsigned       SCLK_MIN_HALF_NS = SCLK_MIN_PHASES * SYS_PHASE_NS;
	localparam int unsigned       CNT_W           = 3;
	localparam logic [CNT_W-1:0]  SCLK_MIN_HALF_CYC =
		CNT_W'((SCLK_MIN_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
	localparam logic [CNT_W-1:0]  CNT_MAX         = 3'h7;

	function automatic logic spm_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
		spm_hit = (addr == off);
	endfunction
endpackage

// ---- spm_sync2.sv ----
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to i_clk_sys.
module spm_sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst_n,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta   <= '0;
			o_sync <= '0;
		end else if (i_ce) begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule // spm_sync2

// ---- spm_pin_cell.sv ----
// One pin's output stage: chooses port or serial drive and registers level and enable.
// Assumes select and direction come from registers on the same clock.
module spm_pin_cell (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	input  wire logic i_serial_sel,
	input  wire logic i_gpio_dir,
	input  wire logic i_gpio_out,
	input  wire logic i_serial_oe,
	input  wire logic i_serial_out,
	output logic      o_pin,
	output logic      o_pin_oe
);
	wire next_oe  = i_serial_sel ? i_serial_oe : i_gpio_dir;
	wire next_out = i_serial_sel ? i_serial_out : i_gpio_out;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pin    <= 1'b0;
			o_pin_oe <= 1'b0;
		end else if (i_ce) begin
			o_pin    <= next_out;
			o_pin_oe <= next_oe;
		end
	end
endmodule // spm_pin_cell

// ---- spm_pin_mux.sv ----
// Top of the serial control pin multiplexer: APB registers, pin routing, bit clock check.
// Assumes an APB master on i_clk_sys and a serial port core on the same clock.
module spm_pin_mux (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_ce,
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [spm_pkg::ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]               i_pwdata,
	output logic      [31:0]               o_prdata,
	output logic                           o_pready,
	output logic                           o_pslverr,
	input  wire logic [spm_pkg::NPIN-1:0]  i_pin,
	output logic      [spm_pkg::NPIN-1:0]  o_pin,
	output logic      [spm_pkg::NPIN-1:0]  o_pin_oe,
	input  wire logic                      i_serial_bit_clock_pin,
	input  wire logic                      i_tx1_data,
	input  wire logic                      i_tx2_data,
	input  wire logic                      i_flag0_out,
	input  wire logic                      i_flag1_out,
	input  wire logic                      i_rx_clk_out,
	input  wire logic                      i_rx_fs_out,
	input  wire logic                      i_fs_internal,
	output logic                           o_rx_clk,
	output logic                           o_rx_fs,
	output logic                           o_tx_fs,
	output logic                           o_flag0_in,
	output logic                           o_flag1_in,
	output logic                           o_sync_mode
);
	import spm_pkg::*;

	logic [NPIN-1:0]  func_sel;
	logic [NPIN-1:0]  dir;
	logic [NPIN-1:0]  gpio_out;
	logic [CFG_W-1:0] ser_cfg;
	logic             clk_fast;
	logic [NPIN:0]    in_sync;
	logic             p0_prev;
	logic             p0_level;
	logic             sclk_prev;
	logic [CNT_W-1:0] sclk_cnt;

	// ==========================================
	// APB decode
	wire setup    = i_psel & ~i_penable;
	wire wr       = i_psel & i_penable & o_pready & i_pwrite;
	wire hit_fsel = spm_hit(i_paddr, OFF_FUNC_SEL);
	wire hit_dir  = spm_hit(i_paddr, OFF_DIR);
	wire hit_gout = spm_hit(i_paddr, OFF_GPIO_OUT);
	wire hit_lvl  = spm_hit(i_paddr, OFF_PIN_LEVEL);
	wire hit_cfg  = spm_hit(i_paddr, OFF_SER_CFG);
	wire hit_stat = spm_hit(i_paddr, OFF_STATUS);
	wire any_hit  = hit_fsel | hit_dir | hit_gout | hit_lvl | hit_cfg | hit_stat;

	wire [NPIN-1:0] pin_lvl = {in_sync[2:1], p0_level};

	wire [31:0] rd_mux =
		hit_fsel ? {29'h0, func_sel} :
		hit_dir  ? {29'h0, dir} :
		hit_gout ? {29'h0, gpio_out} :
		hit_lvl  ? {29'h0, pin_lvl} :
		hit_cfg  ? {23'h0, ser_cfg} :
		hit_stat ? {31'h0, clk_fast} : 32'h0;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0;
			o_pslverr <= 1'b0;
		end else if (i_ce) begin
			o_pready  <= setup;
			o_prdata  <= (setup & ~i_pwrite) ? rd_mux : 32'h0;
			o_pslverr <= setup & ~any_hit;
		end
	end

	// ==========================================
	// Control registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			func_sel <= RST_FUNC_SEL;
			dir      <= RST_DIR;
			gpio_out <= RST_GPIO_OUT;
			ser_cfg  <= RST_SER_CFG;
		end else if (i_ce && wr) begin
			if (hit_fsel) func_sel <= i_pwdata[NPIN-1:0];
			if (hit_dir)  dir      <= i_pwdata[NPIN-1:0];
			if (hit_gout) gpio_out <= i_pwdata[NPIN-1:0];
			if (hit_cfg)  ser_cfg  <= i_pwdata[CFG_W-1:0];
		end
	end

	wire sync_md = ser_cfg[CFG_SYNC];
	wire p0_out  = ser_cfg[CFG_P0_OUT];
	wire p1_out  = ser_cfg[CFG_P1_OUT];
	wire p2_out  = ser_cfg[CFG_P2_OUT];
	wire p0_flag = ser_cfg[CFG_P0_FLAG];
	wire p1_flag = ser_cfg[CFG_P1_FLAG];
	wire f0_out  = ser_cfg[CFG_FLAG0_OUT];
	wire f1_out  = ser_cfg[CFG_FLAG1_OUT];

	// ==========================================
	// Input synchronisers and pin zero hysteresis
	spm_sync2 #(.W(NPIN + 1)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_ce      (i_ce),
		.i_async   ({i_serial_bit_clock_pin, i_pin}),
		.o_sync    (in_sync)
	);

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			p0_prev  <= 1'b0;
			p0_level <= 1'b0;
		end else if (i_ce) begin
			p0_prev <= in_sync[0];
			if (in_sync[0] == p0_prev) p0_level <= p0_prev;
		end
	end

	// ==========================================
	// Serial function drive per pin
	wire ser_oe0  = sync_md ? (p0_flag ? f0_out : 1'b1) : p0_out;
	wire ser_out0 = sync_md ? (p0_flag ? i_flag0_out : i_tx1_data) : i_rx_clk_out;
	wire ser_oe1  = sync_md ? (p1_flag ? f1_out : 1'b1) : p1_out;
	wire ser_out1 = sync_md ? (p1_flag ? i_flag1_out : i_tx2_data) : i_rx_fs_out;
	wire ser_oe2  = p2_out;
	wire ser_out2 = i_fs_internal;

	wire [NPIN-1:0] ser_oe  = {ser_oe2, ser_oe1, ser_oe0};
	wire [NPIN-1:0] ser_out = {ser_out2, ser_out1, ser_out0};

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_cell
			spm_pin_cell u_cell (
				.i_clk_sys    (i_clk_sys),
				.i_rst_n      (i_rst_n),
				.i_ce         (i_ce),
				.i_serial_sel (func_sel[g]),
				.i_gpio_dir   (dir[g]),
				.i_gpio_out   (gpio_out[g]),
				.i_serial_oe  (ser_oe[g]),
				.i_serial_out (ser_out[g]),
				.o_pin        (o_pin[g]),
				.o_pin_oe     (o_pin_oe[g])
			);
		end
	endgenerate

	// ==========================================
	// Received signals towards the serial core
	wire next_rx_clk  = func_sel[0] & ~sync_md & ~p0_out & pin_lvl[0];
	wire next_flag0   = func_sel[0] & sync_md & p0_flag & ~f0_out & pin_lvl[0];
	wire next_flag1   = func_sel[1] & sync_md & p1_flag & ~f1_out & pin_lvl[1];
	wire next_tx_fs   = func_sel[2] & ~p2_out & pin_lvl[2];
	wire next_rx_fs   = sync_md ? next_tx_fs : (func_sel[1] & ~p1_out & pin_lvl[1]);

	// Transmit drive and receive capture share no state, so both run at once
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rx_clk    <= 1'b0;
			o_rx_fs     <= 1'b0;
			o_tx_fs     <= 1'b0;
			o_flag0_in  <= 1'b0;
			o_flag1_in  <= 1'b0;
			o_sync_mode <= 1'b0;
		end else if (i_ce) begin
			o_rx_clk    <= next_rx_clk;
			o_rx_fs     <= next_rx_fs;
			o_tx_fs     <= next_tx_fs;
			o_flag0_in  <= next_flag0;
			o_flag1_in  <= next_flag1;
			o_sync_mode <= sync_md;
		end
	end

	// ==========================================
	// External bit clock rate check
	wire sclk_edge   = in_sync[NPIN] ^ sclk_prev;
	wire sclk_short  = sclk_edge & ser_cfg[CFG_CLK_CHK] & (sclk_cnt < SCLK_MIN_HALF_CYC);
	wire fast_clear  = wr & hit_stat & i_pwdata[STAT_CLK_FAST];
	wire next_fast   = sclk_short | (clk_fast & ~fast_clear);

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sclk_prev <= 1'b0;
			sclk_cnt  <= CNT_MAX;
			clk_fast  <= 1'b0;
		end else if (i_ce) begin
			sclk_prev <= in_sync[NPIN];
			if (sclk_edge) sclk_cnt <= CNT_W'(1);
			else if (sclk_cnt != CNT_MAX) sclk_cnt <= sclk_cnt + CNT_W'(1);
			clk_fast <= next_fast;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	sequence s_ce_prev;
		$past(i_ce);
	endsequence

	reset_gpio_a: assert property ($rose(i_rst_n) |-> func_sel == 3'h0)
		else $error("pins not in port mode after reset");

	gpio_dir_a: assert property (s_ce_prev |-> ((o_pin_oe & ~$past(func_sel)) == ($past(dir) & ~$past(func_sel))))
		else $error("port pin direction mismatch");

	serial_sel_a: assert property (s_ce_prev |-> ((o_pin_oe & $past(func_sel)) == ($past(ser_oe) & $past(func_sel))))
		else $error("serial pin enable wrong");

	rx_clk_a: assert property (s_ce_prev and $past(func_sel[0] & ~sync_md & p0_out)
		|-> o_pin_oe[0] && o_pin[0] == $past(i_rx_clk_out))
		else $error("receiver clock not driven");

	tx1_out_a: assert property (s_ce_prev and $past(func_sel[0] & sync_md & ~p0_flag)
		|-> o_pin_oe[0] && o_pin[0] == $past(i_tx1_data))
		else $error("transmitter 1 not on pin zero");

	rx_fs_a: assert property (s_ce_prev and $past(func_sel[1] & ~sync_md & p1_out)
		|-> o_pin_oe[1] && o_pin[1] == $past(i_rx_fs_out))
		else $error("receiver frame sync not driven");

	tx2_out_a: assert property (s_ce_prev and $past(func_sel[1] & sync_md & ~p1_flag)
		|-> o_pin_oe[1] && o_pin[1] == $past(i_tx2_data))
		else $error("transmitter 2 not on pin one");

	fs_drive_a: assert property (s_ce_prev and $past(func_sel[2] & p2_out)
		|-> o_pin_oe[2] && o_pin[2] == $past(i_fs_internal))
		else $error("internal frame sync not driven");

	fs_input_a: assert property (s_ce_prev and $past(func_sel[2] & ~p2_out & sync_md)
		|-> o_tx_fs == $past(pin_lvl[2]) && o_rx_fs == o_tx_fs)
		else $error("external frame sync not routed");

	clk_fast_a: assert property (i_ce && sclk_short |=> clk_fast)
		else $error("fast bit clock not flagged");

	sequence s_apb_write;
		i_ce && i_psel && i_penable && o_pready && i_pwrite;
	endsequence

	sequence s_ce_two;
		i_ce ##1 i_ce;
	endsequence

	ready_pulse_a: assert property (i_ce && o_pready |=> !o_pready)
		else $error("ready held past the access cycle");

	setup_ready_a: assert property (i_ce && i_psel && !i_penable |=> o_pready)
		else $error("no ready after setup");

	rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside access cycle");

	slverr_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
		else $error("error response malformed");

	fsel_write_a: assert property (s_apb_write ##0 hit_fsel |=> func_sel == $past(i_pwdata[NPIN-1:0]))
		else $error("function select write lost");

	dir_write_a: assert property (s_apb_write ##0 hit_dir |=> dir == $past(i_pwdata[NPIN-1:0]))
		else $error("direction write lost");

	gpio_drive_a: assert property (s_ce_prev
		|-> (o_pin & ~$past(func_sel)) == ($past(gpio_out) & ~$past(func_sel)))
		else $error("port pin level wrong");

	rx_clk_in_a: assert property (s_ce_prev and $past(func_sel[0] & ~sync_md & ~p0_out)
		|-> o_rx_clk == $past(pin_lvl[0]))
		else $error("receiver clock input not passed on");

	pin0_filter_a: assert property (s_ce_two ##1 $changed(p0_level)
		|-> p0_level == $past(in_sync[0]) && p0_level == $past(in_sync[0], 2))
		else $error("pin zero level changed without two equal samples");

	flag0_in_a: assert property (s_ce_prev and $past(func_sel[0] & sync_md & p0_flag & ~f0_out)
		|-> o_flag0_in == $past(pin_lvl[0]))
		else $error("flag 0 input not passed on");

	rx_fs_in_a: assert property (s_ce_prev and $past(func_sel[1] & ~sync_md & ~p1_out)
		|-> o_rx_fs == $past(pin_lvl[1]))
		else $error("receiver frame sync input not passed on");

	flag1_in_a: assert property (s_ce_prev and $past(func_sel[1] & sync_md & p1_flag & ~f1_out)
		|-> o_flag1_in == $past(pin_lvl[1]))
		else $error("flag 1 input not passed on");

	tx_fs_async_a: assert property (s_ce_prev and $past(func_sel[2] & ~p2_out & ~sync_md)
		|-> o_tx_fs == $past(pin_lvl[2]))
		else $error("transmit frame sync input not passed on");

	port_quiet_a: assert property (s_ce_prev and $past(func_sel == 3'h0)
		|-> {o_rx_clk, o_rx_fs, o_tx_fs, o_flag0_in, o_flag1_in} == 5'h0)
		else $error("core sees a pin that is not handed over");

	ce_freeze_a: assert property (!i_ce
		|=> $stable(o_pin) && $stable(o_pin_oe) && $stable(func_sel) && $stable(o_pready))
		else $error("state moved while clock enable low");

	fast_set_a: assert property ($rose(clk_fast) |-> $past(sclk_short))
		else $error("fast flag set without a short half period");

	fast_clear_a: assert property (i_ce && fast_clear && !sclk_short |=> !clk_fast)
		else $error("fast flag not cleared");
endmodule // spm_pin_mux

// ---- spm_far_model.sv ----
// Far-side serial peripheral model: offers control pin levels and the bit clock.
// Resolves each pin here from the block's output enables and drive and this model's levels.
module spm_far_model (
	input  wire logic       i_run,
	input  wire logic       i_fast,
	input  wire logic [2:0] i_drive,
	input  wire logic [2:0] i_val,
	input  wire logic [2:0] i_oe,
	input  wire logic [2:0] i_pin_dut,
	output logic      [2:0] o_pin_w,
	output logic            o_bclk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] spin = 3'h0;
	// ==========================================
	// Pin levels
	// Undriven lines wander so a stale level never passes
	always #10 spin = ~spin;
	// Frame sync and levels offered only where the block is not driving
	assign o_pin_w = (i_oe & i_pin_dut) | (~i_oe & ((i_drive & i_val) | (~i_drive & spin)));
	// ==========================================
	// Bit clock
	// Stands still outside frames; 80 ns half period, 20 ns when told to run too fast
	initial begin
		o_bclk = 1'b0;
		#7;
		forever begin
			#(i_fast ? 20 : 80);
			if (i_run) begin
				o_bclk = ~o_bclk;
			end
		end
	end
endmodule // spm_far_model

// ---- spm_pin_mux_tb.sv ----
// Self-checking bench for the serial control pin multiplexer.
// Assumes the block's own assertions sit inside the design files.
module spm_pin_mux_tb import spm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic              run = 1'b0, fast = 1'b0, ce = 1'b1, pready, pslverr, bclk, e_, sm;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, r;
	logic [NPIN-1:0]   pin_w, pin_o, oe, drv = '1, val = '0;
	logic [6:0]        core = '0;
	logic [4:0]        ins;
	int                seed = 36, miscompares = 0, comparisons = 0, cyc = 0;
	// ==========================================
	// Instances
	spm_pin_mux uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_pin(pin_w), .o_pin(pin_o), .o_pin_oe(oe), .i_serial_bit_clock_pin(bclk),
		.i_tx1_data(core[0]), .i_tx2_data(core[1]), .i_flag0_out(core[2]), .i_flag1_out(core[3]),
		.i_rx_clk_out(core[4]), .i_rx_fs_out(core[5]), .i_fs_internal(core[6]), .o_rx_clk(ins[0]),
		.o_rx_fs(ins[1]), .o_tx_fs(ins[2]), .o_flag0_in(ins[3]), .o_flag1_in(ins[4]), .o_sync_mode(sm));
	spm_far_model far (.i_run(run), .i_fast(fast), .i_drive(drv), .i_val(val), .i_oe(oe),
		.i_pin_dut(pin_o), .o_pin_w(pin_w), .o_bclk(bclk));
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ==========================================
	// Expectations
	function automatic logic [5:0] exp_out(logic [2:0] f, d, g, logic [8:0] c, logic [6:0] k);
		logic [2:0] o, v;
		o = d;
		v = g;
		if (f[0]) begin
			o[0] = c[0] ? (c[4] ? c[6] : 1'b1) : c[1];
			v[0] = c[0] ? (c[4] ? k[2] : k[0]) : k[4];
		end
		if (f[1]) begin
			o[1] = c[0] ? (c[5] ? c[7] : 1'b1) : c[2];
			v[1] = c[0] ? (c[5] ? k[3] : k[1]) : k[5];
		end
		if (f[2]) begin
			o[2] = c[3];
			v[2] = k[6];
		end
		return {o, v};
	endfunction
	function automatic logic [4:0] exp_in(logic [2:0] f, logic [8:0] c, logic [2:0] p);
		return {c[0] & f[1] & c[5] & !c[7] & p[1], c[0] & f[0] & c[4] & !c[6] & p[0],
			f[2] & !c[3] & p[2], c[0] ? (f[2] & !c[3] & p[2]) : (f[1] & !c[2] & p[1]),
			!c[0] & f[0] & !c[1] & p[0]};
	endfunction
	// ==========================================
	// Bus and check tasks
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e_ = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task automatic run_case(input logic [2:0] f, input logic [2:0] d, input logic [8:0] c);
		logic [5:0] e;
		logic [6:0] k;
		logic [2:0] g;
		k = 7'($random(seed));
		g = 3'($random(seed));
		e = exp_out(f, d, g, c, k);
		core <= k;
		drv <= ~e[5:3];
		val <= 3'($random(seed));
		apb(1'b1, OFF_FUNC_SEL, 32'(f));
		apb(1'b1, OFF_DIR, 32'(d));
		apb(1'b1, OFF_GPIO_OUT, 32'(g));
		apb(1'b1, OFF_SER_CFG, 32'(c));
		repeat (8) @(posedge clk);
		chk(32'(oe), 32'(e[5:3]), "pin enables");
		chk(32'(pin_o & e[5:3]), 32'(e[2:0] & e[5:3]), "pin drive");
		chk(32'(ins), 32'(exp_in(f, c, pin_w)), "core inputs");
		chk(32'(sm), 32'(c[0]), "mode flag");
		apb(1'b0, OFF_PIN_LEVEL, 32'h0);
		chk(r, 32'(pin_w), "pin levels");
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'({oe, pin_o, ins}), 32'h0, "reset outputs");
		apb(1'b0, OFF_FUNC_SEL, 32'h0);
		chk(r, 32'h0, "reset select");
		apb(1'b0, 8'h18, 32'h0);
		chk(32'({e_, r[0]}), 32'h2, "unmapped read");
		run_case(3'h0, 3'h7, 9'h000);
		run_case(3'h7, 3'h7, 9'h000);
		run_case(3'h7, 3'h0, 9'h00e);
		ce <= 1'b0;
		core <= ~core;
		repeat (4) @(posedge clk);
		chk(32'(pin_o), 32'({~core[6], ~core[5], ~core[4]}), "frozen drive");
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'(pin_o), 32'({core[6], core[5], core[4]}), "drive after freeze");
		run_case(3'h7, 3'h0, 9'h001);
		run_case(3'h7, 3'h5, 9'h031);
		run_case(3'h7, 3'h0, 9'h0f9);
		repeat (12) run_case(3'($random(seed)), 3'($random(seed)), 9'($random(seed)) & 9'h0ff);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'({oe, pin_o, ins}), 32'h0, "outputs after reset");
		apb(1'b0, OFF_FUNC_SEL, 32'h0);
		chk(r, 32'h0, "select after reset");
		apb(1'b1, OFF_SER_CFG, 32'h100);
		apb(1'b1, OFF_STATUS, 32'h1);
		run <= 1'b1;
		repeat (100) @(posedge clk);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(r, 32'h0, "slow bit clock");
		fast <= 1'b1;
		repeat (20) @(posedge clk);
		run <= 1'b0;
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(r, 32'h1, "fast bit clock");
		apb(1'b1, OFF_STATUS, 32'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(r, 32'h0, "status clear");
		give_verdict();
	end
endmodule // spm_pin_mux_tb
